// *** core/midi_tunnel_pkg.sv ***
// Package holding constants and types for the MIDI user bit tunnel
package midi_tunnel_pkg;

  localparam logic [5:0] CHAN_STD     = 6'h37;  // Channel 56, zero based
  localparam logic [5:0] CHAN_96K     = 6'h1b;  // Channel 28, zero based
  localparam logic [5:0] CHAN_LAST    = 6'h3f;
  localparam logic       LINE_IDLE    = 1'b1;   // MIDI line idles high
  localparam logic [2:0] PRESS_FILTER = 3'h3;   // Cycles for a clean press

  typedef enum logic [1:0] {
    REMOTE_MIDI,
    REMOTE_MADI,
    REMOTE_OFF
  } remote_src_t;

endpackage

// *** core/midi_user_bit_tunnel.sv ***
// MIDI tunnel carried in one MADI channel user bit
`timescale 1ns/1ps
module midi_user_bit_tunnel (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         mode_96k,
  input  wire logic                         remote_press,
  input  wire logic                         midi_in,
  input  wire logic                         rx_valid,
  input  wire logic [5:0]                   rx_chan,
  input  wire logic [23:0]                  rx_audio,
  input  wire logic                         rx_user,
  input  wire logic                         rx_aux,
  output      logic                         tx_valid,
  output      logic [5:0]                   tx_chan,
  output      logic [23:0]                  tx_audio,
  output      logic                         tx_user,
  output      logic                         tx_aux,
  output      logic                         midi_out,
  output      midi_tunnel_pkg::remote_src_t remote_src
);
  import midi_tunnel_pkg::*;

  // Timing: a slot taken at one edge shows on the tx side at the
  // next; midi_out moves one cycle after the tunnel slot arrives.
  // Every output is a flip-flop, so no input reaches a pin without
  // passing a register first.

  // Slot framing: valid and index follow the incoming slot a cycle
  // late, so every outgoing slot keeps its place in the frame.
  logic        next_tx_valid;
  logic [5:0]  next_tx_chan;

  // Slot payload: no routing input reaches this path, so the MIDI
  // tunnel cannot depend on how audio channels are patched.
  logic [23:0] next_tx_audio;
  logic        next_tx_aux;

  // User bit of the outgoing slot, the only field the tunnel touches
  logic        next_tx_user;

  // Local line sampler: registered line, and the per-frame sample
  // held for the next tunnel slot
  logic        midi_line;
  logic        next_midi_line;
  logic        frame_sample;
  logic        next_frame_sample;

  // Line rebuilt from the incoming tunnel slot
  logic        next_midi_out;

  // Selector: stepped state, and the copy that drives the port
  remote_src_t sel;
  remote_src_t next_remote_src;
  logic        forward_madi;

  // Slot decode: combinational, so a slot is recognised in the
  // cycle it arrives and answered at the next edge
  logic [5:0]  midi_chan;
  logic        is_midi_chan;
  logic        frame_end;

  // The press is taken as clean; a bouncing button steps more than
  // once, so any debouncing belongs in front of this block.
  remote_selector u_sel (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .press      (remote_press),
    .remote_src (sel)
  );

  // A mode change in mid frame moves the tunnel slot at once; the
  // frame under way may then carry the bit twice or not at all.
  always_comb begin
    midi_chan    = CHAN_STD;
    is_midi_chan = 1'b0;
    frame_end    = 1'b0;
    // Both channel indexes are zero based
    if (mode_96k) begin
      midi_chan = CHAN_96K;
    end
    // Idle slots carry junk, so decode only what is marked valid
    if (rx_valid) begin
      is_midi_chan = (rx_chan == midi_chan);
      // A frame cut short before its last slot keeps the old
      // sample, so a broken frame repeats the line, never garbles it
      frame_end    = (rx_chan == CHAN_LAST);
    end
  end

  // Decide on the registered selector, so the mode shown on the
  // port is always the one that shapes the outgoing user bit.
  assign forward_madi = (remote_src == REMOTE_MADI);

  always_comb begin
    next_tx_valid = rx_valid;
    next_tx_chan  = rx_chan;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Cleared so nothing downstream sees a slot during reset
      tx_valid <= 1'b0;
      tx_chan  <= '0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_chan  <= next_tx_chan;
    end
  end

  // Audio and the other status bits pass untouched
  always_comb begin
    next_tx_audio = rx_audio;
    next_tx_aux   = rx_aux;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Silence on every channel while in reset
      tx_audio <= '0;
      tx_aux   <= 1'b0;
    end else begin
      tx_audio <= next_tx_audio;
      tx_aux   <= next_tx_aux;
    end
  end

  // Every slot but the tunnel slot passes its own user bit. On the
  // tunnel slot it carries either the forwarded line or the local
  // line sample, never a mix of the two.
  always_comb begin
    next_tx_user = rx_user;
    if (is_midi_chan) begin
      if (forward_madi) begin
        // Local input is kept out of the stream while forwarding
        next_tx_user = rx_user;
      end else begin
        next_tx_user = frame_sample;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // No tunnel data leaves while in reset
      tx_user <= 1'b0;
    end else begin
      tx_user <= next_tx_user;
    end
  end

  // The input is registered once, then held from one frame end to
  // the next, so each frame carries exactly one sample. It is taken
  // at the last slot and rides in the next frame's tunnel slot.
  // Limitation: the serial rate must stay well below the frame rate,
  // or short bits fall between samples and are lost.
  always_comb begin
    next_midi_line    = midi_in;
    next_frame_sample = frame_sample;
    if (frame_end) begin
      next_frame_sample = midi_line;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Idle level, so the first frames carry no false start bit
      midi_line    <= LINE_IDLE;
      frame_sample <= LINE_IDLE;
    end else begin
      midi_line    <= next_midi_line;
      frame_sample <= next_frame_sample;
    end
  end

  // The output follows the tunnel slot's user bit and holds it until
  // the next frame, rebuilding the far-end line. A frame that never
  // reaches the tunnel slot leaves it as it was. Bit edges on the
  // output are therefore quantised to the frame period.
  always_comb begin
    next_midi_out = midi_out;
    if (is_midi_chan) begin
      next_midi_out = rx_user;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Idle level, so a listener sees no start bit after reset
      midi_out <= LINE_IDLE;
    end else begin
      midi_out <= next_midi_out;
    end
  end

  // The port copy lags the stepping logic by a cycle. Forwarding
  // keys off this copy, so a new mode applies from the first slot
  // after the port shows it.
  always_comb begin
    next_remote_src = sel;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Reset hands control back to the local MIDI port
      remote_src <= REMOTE_MIDI;
    end else begin
      remote_src <= next_remote_src;
    end
  end

endmodule

// *** core/remote_selector.sv ***
// Remote source selector stepping MIDI, MADI, off on each press
`timescale 1ns/1ps
module remote_selector (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         press,
  output      midi_tunnel_pkg::remote_src_t remote_src
);
  import midi_tunnel_pkg::*;

  remote_src_t state;
  remote_src_t next_state;
  logic        press_last;
  logic        next_press_last;

  assign remote_src = state;

  always_comb begin
    next_press_last = press;
    next_state      = state;
    // Rising edge only, so a held button steps once
    if (press && !press_last) begin
      unique case (state)
        REMOTE_MIDI: next_state = REMOTE_MADI;
        REMOTE_MADI: next_state = REMOTE_OFF;
        REMOTE_OFF:  next_state = REMOTE_MIDI;
        default:     next_state = REMOTE_MIDI;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= REMOTE_MIDI;
      press_last <= 1'b0;
    end else begin
      state      <= next_state;
      press_last <= next_press_last;
    end
  end

endmodule

// *** dv/madi_source.sv ***
// Far-end MADI sender model
`timescale 1ns/1ps
module madi_source (
  output logic        rx_valid,
  output logic [5:0]  rx_chan,
  output logic [23:0] rx_audio,
  output logic        rx_user,
  output logic        rx_aux
);
  initial {rx_valid, rx_chan, rx_audio, rx_user, rx_aux} = '0;
  // Fields differ per channel so a slipped slot shows
  task automatic slot(input logic [5:0] c, input logic u);
    {rx_valid, rx_chan, rx_user, rx_aux} = {1'b1, c, u, c[1]};
    rx_audio = {c, 18'h2b5c3};
  endtask
  // Released chan, audio and user lines flip so stale data never looks valid
  task automatic idle();
    rx_valid = 1'b0;
    {rx_chan, rx_audio, rx_user} = ~{rx_chan, rx_audio, rx_user};
  endtask
endmodule

// *** dv/midi_user_bit_tunnel_properties.sv ***
// Port checker for the MIDI user bit tunnel
`timescale 1ns/1ps
module midi_user_bit_tunnel_properties (
  input wire logic                         sys_clk,
  input wire logic                         rst_n,
  input wire logic                         mode_96k,
  input wire logic                         rx_valid,
  input wire logic [5:0]                   rx_chan,
  input wire logic [23:0]                  rx_audio,
  input wire logic                         rx_user,
  input wire logic                         rx_aux,
  input wire logic                         tx_valid,
  input wire logic [5:0]                   tx_chan,
  input wire logic [23:0]                  tx_audio,
  input wire logic                         tx_user,
  input wire logic                         tx_aux,
  input wire logic                         midi_out,
  input wire midi_tunnel_pkg::remote_src_t remote_src
);
  import midi_tunnel_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire m = rx_valid && rx_chan == (mode_96k ? CHAN_96K : CHAN_STD);
  property p_au; rx_valid |=> tx_audio == $past(rx_audio); endproperty
  a_au: assert property (p_au) else $error("audio");
  property p_va; tx_valid == $past(rx_valid); endproperty
  a_va: assert property (p_va) else $error("valid");
  property p_ch; rx_valid |=> {tx_chan, tx_aux} == $past({rx_chan, rx_aux});
  endproperty
  a_ch: assert property (p_ch) else $error("chan");
  property p_ot; rx_valid && !m |=> tx_user == $past(rx_user); endproperty
  a_ot: assert property (p_ot) else $error("user");
  property p_fw; m && remote_src == REMOTE_MADI |=> tx_user == $past(rx_user);
  endproperty
  a_fw: assert property (p_fw) else $error("forward");
  property p_rx; m |=> midi_out == $past(rx_user); endproperty
  a_rx: assert property (p_rx) else $error("extract");
  property p_hd; !m |=> $stable(midi_out); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_st; $changed(remote_src) |->
    remote_src == ($past(remote_src) + 1) % 3; endproperty
  a_st: assert property (p_st) else $error("step");
endmodule
bind midi_user_bit_tunnel midi_user_bit_tunnel_properties u_chk (.*);

// *** dv/midi_user_bit_tunnel_test.sv ***
// Self-checking bench for the MIDI user bit tunnel
`timescale 1ns/1ps
module midi_user_bit_tunnel_test;
  import midi_tunnel_pkg::*;
  logic sys_clk = 0, rst_n = 0, mode_96k = 0, remote_press = 0, midi_in = 1;
  logic rx_valid, rx_user, rx_aux, tx_valid, tx_user, tx_aux, midi_out;
  logic [5:0] rx_chan, tx_chan;
  logic [23:0] rx_audio, tx_audio;
  remote_src_t remote_src;
  int mismatches = 0, total_checks = 0;
  madi_source u_src (.rx_valid, .rx_chan, .rx_audio, .rx_user, .rx_aux);
  midi_user_bit_tunnel u_dut (.sys_clk, .rst_n, .mode_96k, .remote_press,
    .midi_in, .rx_valid, .rx_chan, .rx_audio, .rx_user, .rx_aux, .tx_valid,
    .tx_chan, .tx_audio, .tx_user, .tx_aux, .midi_out, .remote_src);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Two frames: the line is taken at frame end, so judge the second
  task automatic frame(input logic [63:0] u, input logic ln);
    int m;
    logic [5:0] s;
    m = mode_96k ? CHAN_96K : CHAN_STD;
    midi_in = ln;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c <= 64; c++) begin
        @(negedge sys_clk);
        s = 6'(c - 1);
        if (r == 1 && c == 0) begin
          chk(tx_valid, 1'b0);
          // Flipped after the frame end: must not reach this frame
          midi_in = ~ln;
        end
        if (c > 0) begin
          chk(tx_audio, {s, 18'h2b5c3});
          chk({tx_valid, tx_chan, tx_aux}, {1'b1, s, s[1]});
          if (r == 1 || c - 1 != m)
            chk(tx_user, (c - 1 == m && remote_src != REMOTE_MADI) ? ln
              : u[c - 1]);
        end
        if (c < 64) u_src.slot(6'(c), u[c]);
        else u_src.idle();
      end
    end
    chk(midi_out, u[m]);
  endtask
  task automatic press(input remote_src_t exp);
    remote_press = 1;
    repeat (8) @(negedge sys_clk);
    remote_press = 0;
    repeat (8) @(negedge sys_clk);
    chk(remote_src, exp);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1;
    chk({midi_out, remote_src}, {LINE_IDLE, REMOTE_MIDI});
    frame(64'h00c0_5a5a_0000_ffff, 1'b0);
    mode_96k = 1;
    frame(64'hffff_0000_f3ff_ffff, 1'b1);
    press(REMOTE_MADI);
    frame(64'h0000_ffff_0800_0000, 1'b0);
    press(REMOTE_OFF);
    mode_96k = 0;
    frame(64'hff0f_0000_00ff_00ff, 1'b1);
    press(REMOTE_MIDI);
    complete_run();
  end
endmodule
